/* File: design/cbss_defines.svh */
// timing counts and widths for the card socket system signal block
`ifndef CBSS_DEFINES_SVH
`define CBSS_DEFINES_SVH
`define CBSS_SYS_PERIOD_PS   4000
`define CBSS_FULL_PERIOD_PS  80000
`define CBSS_FULL_HALF_CYC   ((`CBSS_FULL_PERIOD_PS / `CBSS_SYS_PERIOD_PS) / 2)
`define CBSS_SLOW_HALF_CYC   40
`define CBSS_ANNOUNCE_EDGES  4
`define CBSS_ASYNC_W         8
`endif

/* File: design/cbss_pkg.sv */
// types shared by the card socket system signal block
package cbss_pkg;
  // requested socket clock speed
  typedef enum logic [1:0] {SPD_FULL, SPD_SLOW, SPD_STOP} cbss_speed_e;
  // socket clock control states
  typedef enum logic [1:0] {CK_RUN, CK_ANNOUNCE, CK_SLOW, CK_STOP} cbss_clk_e;
  // bus transfer phases
  typedef enum logic [1:0] {X_IDLE, X_ADDR, X_DATA, X_LAST} cbss_xfer_e;
  // asynchronous socket inputs other than clock-run
  typedef struct packed {
    logic socket_interrupt;
    logic socket_status_change;
    logic socket_audio;
    logic socket_detect_1;
    logic socket_detect_2;
    logic socket_voltage_sense_1;
    logic socket_voltage_sense_2;
  } cbss_async_s;
  // one single-data-phase transfer request
  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  be;
    logic [31:0] data;
  } cbss_xfer_s;
endpackage : cbss_pkg

/* File: design/cbss_socket_sys.sv */
// socket-side clock, clock-run, reset and address/data driver for one card socket
//
// Functional notes
// - socket signals sampled on socket clock rise
// - clock at bus rate, slowed or stopped low
// - announce clock decrease on clock-run first
// - during card reset all socket drivers released
// - reset asserts anytime, releases on clock edge
// - address phase carries full 32-bit address
// - data phase carries data, bit 31 MSB
// - command in address, byte enables in data
// - even parity, driven one clock later, checked
`include "cbss_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cbss_socket_sys #(
  parameter int SLOW_HALF = `CBSS_SLOW_HALF_CYC   // half period when slowed
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 sys_rst_in,
  input  wire cbss_pkg::cbss_speed_e speed_req_in,
  input  wire logic                 card_reset_req_in,
  input  wire logic                 xfer_valid_in,
  input  wire cbss_pkg::cbss_xfer_s xfer_in,
  output logic                      xfer_ready_out,
  output logic                      done_out,
  output logic [31:0]               rd_data_out,
  output logic                      par_err_out,
  output cbss_pkg::cbss_clk_e       clk_state_out,
  input  wire cbss_pkg::cbss_async_s async_in,
  output cbss_pkg::cbss_async_s     async_sync_out,
  output logic                      socket_clock_out,
  output logic                      socket_reset_n_out,
  input  wire logic                 socket_clock_run_n_in,
  output logic                      socket_clock_run_n_out,
  output logic                      socket_clock_run_n_oe_out,
  input  wire logic [31:0]          socket_addr_data_in,
  output logic [31:0]               socket_addr_data_out,
  output logic                      socket_addr_data_oe_out,
  input  wire logic [3:0]           socket_cmd_byte_enable_in,
  output logic [3:0]                socket_cmd_byte_enable_out,
  output logic                      socket_cmd_byte_enable_oe_out,
  input  wire logic                 socket_parity_in,
  output logic                      socket_parity_out,
  output logic                      socket_parity_oe_out
);
  localparam int FULL_HALF = `CBSS_FULL_HALF_CYC;
  localparam int AW        = `CBSS_ASYNC_W;

  // refuse settings the divider cannot serve, at elaboration
  if (SLOW_HALF < FULL_HALF || SLOW_HALF > 65535 || FULL_HALF < 1) begin : g_bad_half
    $error("cbss_socket_sys: bad clock half period");
  end

  cbss_pkg::cbss_clk_e  ck_state;      // clock control state
  cbss_pkg::cbss_xfer_e xs;            // transfer phase
  cbss_pkg::cbss_xfer_s req;           // latched request
  logic                 pend;          // request waiting for a clock rise
  logic [15:0]          div_cnt;       // divider count
  logic [2:0]           ann_cnt;       // announce edges seen
  logic [AW-1:0]        s1, s2, s3;    // synchroniser stages
  logic [AW-1:0]        filt;          // agreed input levels

  // asynchronous inputs, clock-run on top
  wire [AW-1:0] raw       = {socket_clock_run_n_in, async_in};
  wire          run_req   = ~filt[AW-1];     // card pulls clock-run low
  wire [15:0]   half      = (ck_state == cbss_pkg::CK_SLOW) ? 16'(SLOW_HALF) : 16'(FULL_HALF);
  wire          wrap      = (div_cnt == half - 16'h0001);
  // a stopped clock only parks after its high half ends
  wire          may_tog   = socket_clock_out || (ck_state != cbss_pkg::CK_STOP);
  wire          rise_tick = wrap && may_tog && !socket_clock_out;
  wire          idle_ok   = (xs == cbss_pkg::X_IDLE) && !pend;
  wire          want_down = (speed_req_in != cbss_pkg::SPD_FULL) && idle_ok;
  wire          par_calc  = ^{socket_addr_data_out, socket_cmd_byte_enable_out};
  wire          par_rd    = ^{socket_addr_data_in, socket_cmd_byte_enable_out};

  assign clk_state_out  = ck_state;
  assign async_sync_out = filt[AW-2:0];
  assign xfer_ready_out = idle_ok && socket_reset_n_out && (ck_state == cbss_pkg::CK_RUN);

  // three-stage synchroniser per input; only s2 reads s1
  genvar gi;
  generate
    for (gi = 0; gi < AW; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          s1[gi]   <= 1'b1;
          s2[gi]   <= 1'b1;
          s3[gi]   <= 1'b1;
          filt[gi] <= 1'b1;
        end else begin
          s1[gi] <= raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) filt[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  // socket clock divider; parked low when stopped
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      div_cnt          <= 16'h0000;
      socket_clock_out <= 1'b0;
    end else if (wrap) begin
      div_cnt <= 16'h0000;
      if (may_tog) socket_clock_out <= !socket_clock_out;
    end else if (!may_tog && !socket_clock_out) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // clock speed control with clock-run handshake
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ck_state <= cbss_pkg::CK_RUN;
      ann_cnt  <= 3'h0;
    end else begin
      case (ck_state)
        cbss_pkg::CK_RUN: begin
          ann_cnt <= 3'h0;
          if (want_down) ck_state <= cbss_pkg::CK_ANNOUNCE;
        end
        cbss_pkg::CK_ANNOUNCE: begin
          // own drive-low may linger in the synchroniser until a full
          // socket clock has passed, so card requests count from the second rise
          if ((ann_cnt > 3'h1 && run_req) || !want_down) begin
            ck_state <= cbss_pkg::CK_RUN;
          end else if (rise_tick) begin
            if (ann_cnt == 3'(`CBSS_ANNOUNCE_EDGES - 1)) begin
              ck_state <= (speed_req_in == cbss_pkg::SPD_STOP) ?
                          cbss_pkg::CK_STOP : cbss_pkg::CK_SLOW;
            end
            ann_cnt <= ann_cnt + 3'h1;
          end
        end
        default: begin
          // slow or stopped: card request or user request restores speed
          if (run_req || speed_req_in == cbss_pkg::SPD_FULL) begin
            ck_state <= cbss_pkg::CK_RUN;
          end
        end
      endcase
    end
  end

  // clock-run held low while running at full speed, released to announce
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      socket_clock_run_n_out    <= 1'b0;
      socket_clock_run_n_oe_out <= 1'b0;
    end else begin
      socket_clock_run_n_out    <= 1'b0;
      socket_clock_run_n_oe_out <= socket_reset_n_out &&
                                   (ck_state == cbss_pkg::CK_RUN);
    end
  end

  // card reset: asserted on any edge, released only at a clock rise
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || card_reset_req_in) begin
      socket_reset_n_out <= 1'b0;
    end else if (rise_tick) begin
      socket_reset_n_out <= 1'b1;
    end
  end

  // transfer sequencer, socket outputs change on socket clock rises
  // a card reset request drops the address, command and parity drivers in the same cycle as the reset pin
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || card_reset_req_in || !socket_reset_n_out) begin
      xs                            <= cbss_pkg::X_IDLE;
      req                           <= '0;
      pend                          <= 1'b0;
      socket_addr_data_out          <= 32'h0000_0000;
      socket_addr_data_oe_out       <= 1'b0;
      socket_cmd_byte_enable_out    <= 4'h0;
      socket_cmd_byte_enable_oe_out <= 1'b0;
      socket_parity_out             <= 1'b0;
      socket_parity_oe_out          <= 1'b0;
      done_out                      <= 1'b0;
      par_err_out                   <= 1'b0;
      rd_data_out                   <= 32'h0000_0000;
    end else begin
      done_out    <= 1'b0;
      par_err_out <= 1'b0;
      if (xfer_valid_in && xfer_ready_out) begin
        req  <= xfer_in;
        pend <= 1'b1;
      end
      if (rise_tick) begin
        case (xs)
          cbss_pkg::X_IDLE: begin
            socket_parity_oe_out <= 1'b0;
            if (pend) begin
              pend                          <= 1'b0;
              xs                            <= cbss_pkg::X_ADDR;
              socket_addr_data_out          <= req.addr;
              socket_addr_data_oe_out       <= 1'b1;
              socket_cmd_byte_enable_out    <= req.cmd;
              socket_cmd_byte_enable_oe_out <= 1'b1;
            end
          end
          cbss_pkg::X_ADDR: begin
            xs                         <= cbss_pkg::X_DATA;
            socket_parity_out          <= par_calc;
            socket_parity_oe_out       <= 1'b1;
            socket_cmd_byte_enable_out <= req.be;
            // reads hand the lines to the card
            socket_addr_data_out       <= req.wr ? req.data : 32'h0000_0000;
            socket_addr_data_oe_out    <= req.wr;
          end
          cbss_pkg::X_DATA: begin
            xs                            <= cbss_pkg::X_LAST;
            socket_parity_out             <= par_calc;
            socket_parity_oe_out          <= req.wr;
            socket_addr_data_oe_out       <= 1'b0;
            socket_cmd_byte_enable_oe_out <= 1'b0;
            if (!req.wr) rd_data_out <= socket_addr_data_in;
            if (!req.wr) socket_cmd_byte_enable_out <= req.be;
          end
          default: begin
            // card parity for read data arrives one clock later
            xs                   <= cbss_pkg::X_IDLE;
            done_out             <= 1'b1;
            socket_parity_oe_out <= 1'b0;
            if (!req.wr) par_err_out <= (socket_parity_in !=
                                         ^{rd_data_out, req.be});
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  stop_parks_low_a: assert property ((ck_state == cbss_pkg::CK_STOP && !socket_clock_out)
    |=> !socket_clock_out) else $error("stopped clock left low");
  announce_first_a: assert property ((ck_state inside {cbss_pkg::CK_SLOW, cbss_pkg::CK_STOP}
    && $past(ck_state) == cbss_pkg::CK_RUN) |-> 1'b0) else $error("decrease without notice");
  announce_release_a: assert property ((ck_state == cbss_pkg::CK_ANNOUNCE) |=>
    !socket_clock_run_n_oe_out) else $error("clock-run not released");
  card_wakes_a: assert property ((ck_state == cbss_pkg::CK_SLOW && run_req) |=>
    ck_state == cbss_pkg::CK_RUN) else $error("card run request ignored");
  reset_async_a: assert property (card_reset_req_in |=> !socket_reset_n_out)
    else $error("card reset not asserted");
  reset_release_a: assert property ($rose(socket_reset_n_out) |-> $rose(socket_clock_out))
    else $error("reset released off clock rise");
  reset_quiet_a: assert property (!socket_reset_n_out ##1 !socket_reset_n_out |->
    !(socket_addr_data_oe_out || socket_cmd_byte_enable_oe_out || socket_parity_oe_out
      || socket_clock_run_n_oe_out)) else $error("driving during reset");
  addr_phase_a: assert property (xs == cbss_pkg::X_ADDR |-> socket_addr_data_oe_out &&
    socket_addr_data_out == req.addr && socket_cmd_byte_enable_out == req.cmd)
    else $error("bad address phase");
  data_phase_a: assert property ((xs == cbss_pkg::X_DATA && req.wr) |-> socket_addr_data_out
    == req.data && socket_cmd_byte_enable_out == req.be) else $error("bad data phase");
  parity_late_a: assert property ($rose(socket_parity_oe_out) |-> socket_parity_out ==
    ^{$past(socket_addr_data_out), $past(socket_cmd_byte_enable_out)})
    else $error("parity not one clock late");
  sync_agree_a: assert property (((filt ^ $past(filt)) & ($past(s2) ^ $past(s3))) == '0)
    else $error("input taken before stages agree");

  slow_seen_c: cover property (ck_state == cbss_pkg::CK_SLOW);
  stop_seen_c: cover property (ck_state == cbss_pkg::CK_STOP && !socket_clock_out);
  write_done_c: cover property (done_out && req.wr);
  read_perr_c: cover property (par_err_out);
endmodule : cbss_socket_sys
`default_nettype wire

/* File: tb/cbss_card_model.sv */
// behavioural card seated in the socket, target side only
`timescale 1ns/1ps
`default_nettype none
module cbss_card_model (
  input  wire logic        sclk_in,      // socket clock
  input  wire logic        srst_n_in,    // card reset, active low
  input  wire logic        frame_in,     // controller drives cmd lines
  input  wire logic [3:0]  cbe_in,       // resolved cmd / byte enables
  input  wire logic [31:0] rd_value_in,  // data returned on reads
  input  wire logic        bad_par_in,   // corrupt the read parity
  input  wire logic        want_fast_in, // ask for the full clock rate
  output logic      [31:0] ad_out,       // card side of address/data
  output logic             par_out,      // card parity
  output logic             par_oe_out,   // card drives parity
  output logic             run_pull_out  // pulls clock-run low
);
  logic [1:0] phase; // 0 idle, 1 address seen, 2 data out, 3 parity out
  logic       rd;    // current cycle is a read
  logic [3:0] be;    // enables of the data phase
  // known start so the toggling idle pattern is never unknown
  initial begin
    ad_out = 32'h0;
    par_out = 1'b0;
    phase = 2'h0;
  end
  assign run_pull_out = want_fast_in;
  // sample mid-period: values launched at the rise have settled
  always @(negedge sclk_in or negedge srst_n_in) begin
    if (!srst_n_in) begin
      phase      <= 2'h0;
      par_oe_out <= 1'b0;
    end else begin
      ad_out  <= ~ad_out; // a released line never keeps a stale value
      par_out <= ~par_out;
      case (phase)
        2'h0: if (frame_in) begin
          phase <= 2'h1;
          rd    <= ~cbe_in[0];
        end
        2'h1: begin
          phase <= 2'h2;
          be    <= cbe_in;
          if (rd) ad_out <= rd_value_in;
        end
        2'h2: begin
          phase      <= 2'h3;
          par_out    <= ^{rd_value_in, be} ^ bad_par_in;
          par_oe_out <= rd;
        end
        default: begin
          phase      <= 2'h0;
          par_oe_out <= 1'b0;
        end
      endcase
    end
  end
endmodule : cbss_card_model
`default_nettype wire

/* File: tb/tb_cbss_socket_sys.sv */
// self-checking bench for the card socket system signal block
`timescale 1ns/1ps
`default_nettype none
`include "cbss_defines.svh"
module tb_cbss_socket_sys;
  localparam int SH = 12; // shortened slow half period
  logic        clk_sys_in, sys_rst_in, crr, xv, ready, done, perr, sck, srn, pk;
  logic        run_o, run_oe, run_w, ad_oe, cbe_oe, par_o, par_oe, par_w;
  logic        k_par, k_poe, pull, badp, fast;
  logic [31:0] rdd, ad_o, ad_w, k_ad, rdv;
  logic [3:0]  cbe_o, cbe_w;
  int          n_errors, samples_checked, seed, k, n;
  cbss_pkg::cbss_speed_e speed;
  cbss_pkg::cbss_xfer_s  x;
  cbss_pkg::cbss_clk_e   cst;
  cbss_pkg::cbss_async_s ain, aso;
  // clock-run is pulled up; a driving card wins the parity line
  assign run_w = (run_oe ? run_o : 1'b1) & ~pull;
  assign ad_w  = ad_oe ? ad_o : k_ad;
  assign cbe_w = cbe_oe ? cbe_o : ~cbe_o;
  assign par_w = (k_poe | ~par_oe) ? k_par : par_o;
  cbss_socket_sys #(.SLOW_HALF(SH)) u_cbss_socket_sys (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .speed_req_in(speed),
    .card_reset_req_in(crr), .xfer_valid_in(xv), .xfer_in(x), .xfer_ready_out(ready),
    .done_out(done), .rd_data_out(rdd), .par_err_out(perr), .clk_state_out(cst),
    .async_in(ain), .async_sync_out(aso), .socket_clock_out(sck),
    .socket_reset_n_out(srn), .socket_clock_run_n_in(run_w),
    .socket_clock_run_n_out(run_o), .socket_clock_run_n_oe_out(run_oe),
    .socket_addr_data_in(ad_w), .socket_addr_data_out(ad_o),
    .socket_addr_data_oe_out(ad_oe), .socket_cmd_byte_enable_in(cbe_w),
    .socket_cmd_byte_enable_out(cbe_o), .socket_cmd_byte_enable_oe_out(cbe_oe),
    .socket_parity_in(par_w), .socket_parity_out(par_o), .socket_parity_oe_out(par_oe));
  cbss_card_model u_cbss_card_model (.sclk_in(sck), .srst_n_in(srn), .frame_in(cbe_oe),
    .cbe_in(cbe_w), .rd_value_in(rdv), .bad_par_in(badp), .want_fast_in(fast),
    .ad_out(k_ad), .par_out(k_par), .par_oe_out(k_poe), .run_pull_out(pull));
  // system clock, 4 ns
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  // inputs move 1 ns after the edge
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_in);
    #1;
  endtask : tick
  function automatic logic par_of(input logic [31:0] d, input logic [3:0] b);
    return ^{d, b}; // even parity over both buses
  endfunction : par_of
  // high time of the socket clock in system cycles
  task automatic half(input int h);
    int c;
    c = 0;
    @(posedge sck);
    #1;
    while (sck === 1'b1 && c < 200) begin
      tick(1);
      c++;
    end
    chk(c == h, "socket clock half period");
  endtask : half
  task automatic wait_state(input cbss_pkg::cbss_clk_e s);
    n = 0;
    while (cst !== s && n < 400) begin
      tick(1);
      n++;
    end
    chk(cst === s, "clock control state");
  endtask : wait_state
  // one transfer, wire phases checked mid socket clock period
  task automatic xfer(input logic wr, input logic bad);
    cbss_pkg::cbss_xfer_s t;
    t = {wr, 32'($random(seed)), 3'b011, wr, 4'($random(seed)), 32'($random(seed))};
    rdv = $random(seed);
    badp = bad;
    x = t;
    xv = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    tick(1);
    xv = 1'b0;
    @(posedge sck);
    @(negedge sck);
    chk(ad_w === t.addr && cbe_w === t.cmd, "address phase");
    @(negedge sck);
    chk(cbe_w === t.be && par_w === par_of(t.addr, t.cmd), "enables, parity");
    if (wr) chk(ad_w === t.data, "write data");
    @(negedge sck);
    if (wr) chk(par_w === par_of(t.data, t.be), "write parity");
    while (done !== 1'b1 && n < 700) begin
      tick(1);
      n++;
    end
    chk(done === 1'b1 && perr === (bad & ~wr), "done, parity flag");
    if (!wr) chk(rdd === rdv, "read data");
  endtask : xfer
  // watchdog well beyond the expected run
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
  initial begin
    seed = 32'hCEF0;
    n_errors = 0;
    samples_checked = 0;
    sys_rst_in = 1'b1;
    {crr, xv, badp, fast, x, rdv} = '0;
    speed = cbss_pkg::SPD_FULL;
    ain = '1;
    tick(8);
    chk(srn === 1'b0 && sck === 1'b0 && {ad_oe, cbe_oe, par_oe} === 3'h0, "reset");
    sys_rst_in = 1'b0;
    half(`CBSS_FULL_HALF_CYC);
    for (k = 0; k < 8; k++) xfer(k[0], k == 4);
    for (k = 0; k < 3; k++) begin
      ain = 7'($random(seed));
      tick(4);
      chk(aso === ain, "synchronised inputs");
    end
    speed = cbss_pkg::SPD_SLOW;
    tick(4);
    chk(cst === cbss_pkg::CK_ANNOUNCE && run_oe === 1'b0, "announce first");
    wait_state(cbss_pkg::CK_SLOW);
    half(SH);
    fast = 1'b1;
    wait_state(cbss_pkg::CK_RUN);
    speed = cbss_pkg::SPD_FULL;
    tick(3);
    chk(run_oe === 1'b1, "clock-run held at full rate");
    fast = 1'b0;
    speed = cbss_pkg::SPD_STOP;
    wait_state(cbss_pkg::CK_STOP);
    // the stop takes effect at a rise, so let the high half run out first
    tick(`CBSS_FULL_HALF_CYC);
    n = 0;
    repeat (60) begin
      tick(1);
      if (sck !== 1'b0) n++;
    end
    chk(n == 0, "stopped clock low");
    speed = cbss_pkg::SPD_FULL;
    fast = 1'b1;
    wait_state(cbss_pkg::CK_RUN);
    fast = 1'b0;
    // card reset in the middle of a write
    x = {1'b1, 32'hA5A5_0000, 4'h7, 4'hF, 32'h1234_5678};
    xv = 1'b1;
    tick(2);
    xv = 1'b0;
    tick(25);
    crr = 1'b1;
    tick(1);
    chk(srn === 1'b0 && {ad_oe, cbe_oe, par_oe} === 3'h0, "card reset");
    crr = 1'b0;
    n = 0;
    while (srn !== 1'b1 && n < 100) begin
      pk = sck;
      tick(1);
      n++;
    end
    chk(srn === 1'b1 && sck === 1'b1 && pk === 1'b0, "release on rise");
    xfer(1'b0, 1'b0);
    end_of_test;
  end
endmodule : tb_cbss_socket_sys
`default_nettype wire
